// [common/eix_pkg.sv]
// Constants shared by the extended indexed instruction executor.
// Assumes one core clock edge per instruction cycle; no other imports.
package eix_pkg;

    // Opcode patterns and the bit fields that select them.
    localparam logic [9:0] ADD_RET_OPCODE = 10'h3A3;
    localparam int ADD_RET_OP_LSB = 6;
    localparam logic [15:0] CALL_W_OPCODE = 16'h0014;
    localparam logic [8:0] MOVE_W1_OPCODE = 9'h1D6;
    localparam int MOVE_W1_OP_LSB = 7;
    localparam logic [3:0] MOVE_W2_OPCODE = 4'hF;
    localparam int MOVE_W2_OP_LSB = 12;

    // Field widths.
    localparam int LIT_W = 6;
    localparam int OFFS_W = 7;
    localparam int ADDR_W = 12;
    localparam int PC_W = 21;
    localparam int BYTE_W = 8;

    // Step from the current word to the next instruction address.
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

    // Reset and fill values.
    localparam logic [ADDR_W-1:0] INDEX_RESET = 12'h000;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [BYTE_W-1:0] INDIRECT_READ_VALUE = 8'h00;

    // Indirect addressing registers: three groups of consecutive addresses.
    localparam int IND_GRPS = 3;
    localparam logic [ADDR_W-1:0] IND_GRP_SIZE = 12'h005;
    localparam logic [ADDR_W-1:0] IND_GRP_BASE [IND_GRPS] = '{12'hFEB, 12'hFE3, 12'hFDB};

    // Sequencer states, Gray coded along decode -> second word / flush.
    typedef enum logic [1:0] {
        EIX_DECODE = 2'b00,
        EIX_MOVE_W2 = 2'b01,
        EIX_FLUSH = 2'b10
    } eix_state_type;

endpackage

// [design/eix_exec.sv]
// Decode and execute logic for three extended instructions of an 8-bit core.
// Assumes one instruction word per clock, data memory answering a read on the next edge,
// and that the stack, flags and standard instructions live outside this block.
//
// What this block does
// - Add-literal-and-return is one word of two cycles: the pointer is written in the first, the second is idle.
// - Add-literal-and-return adds its unsigned 6-bit literal to the third index pointer and reloads the PC from the stack top.
// - Add-literal-and-return is recognised as upper byte 1110 1000, next two bits 11, then six literal bits.
// - The computed call is the single fixed word 0000 0000 0001 0100 and takes two cycles, the second idle.
// - The computed call pushes the next instruction address and loads PC from the working register and the latches.
// - The high and upper PC bytes of the computed call are the latch contents at execution time.
// - The computed call leaves the working register, flags and bank select untouched and has no shadow save.
// - The indexed-to-absolute move is two words, 1110 1011 0 plus a 7-bit offset, then 1111 plus a 12-bit address.
// - The move source address is the unsigned 7-bit offset added to the current third index pointer.
// - Source and destination addresses of the move span the whole 4096-byte data space.
// - A move whose source address hits an indirect addressing register moves the value 00h.
`timescale 1ns/100ps

module eix_exec (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic [20:0] pc_in,
    input wire logic [7:0] working_register_in,
    input wire logic [7:0] pc_high_latch_in,
    input wire logic [7:0] pc_upper_latch_in,
    input wire logic [20:0] stack_top_in,
    input wire logic index_load_in,
    input wire logic [11:0] index_load_value_in,
    input wire logic [7:0] rd_data_in,
    output logic [11:0] third_index_pointer_out,
    output logic pc_load_out,
    output logic [20:0] pc_value_out,
    output logic push_out,
    output logic [20:0] push_value_out,
    output logic rd_req_out,
    output logic [11:0] rd_addr_out,
    output logic wr_req_out,
    output logic [11:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    output logic discard_out,
    output logic busy_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    eix_pkg::eix_state_type state_q, state_d;
    logic [11:0] index_q, index_d;
    logic src_ind_q, src_ind_d;
    logic pc_load_q, pc_load_d;
    logic [20:0] pc_value_q, pc_value_d;
    logic push_q, push_d;
    logic [20:0] push_value_q, push_value_d;
    logic rd_req_q, rd_req_d;
    logic [11:0] rd_addr_q, rd_addr_d;
    logic wr_req_q, wr_req_d;
    logic [11:0] wr_addr_q, wr_addr_d;
    logic [7:0] wr_data_q, wr_data_d;
    logic discard_q, discard_d;
    logic busy_q, busy_d;
    logic is_add_ret;
    logic is_call_w;
    logic is_move_w1;
    logic is_move_w2;
    logic [11:0] src_addr;
    logic [eix_pkg::IND_GRPS-1:0] ind_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Opcode decode.

    assign is_add_ret = instr_word_in[15:eix_pkg::ADD_RET_OP_LSB] == eix_pkg::ADD_RET_OPCODE;
    assign is_call_w = instr_word_in == eix_pkg::CALL_W_OPCODE;
    assign is_move_w1 = instr_word_in[15:eix_pkg::MOVE_W1_OP_LSB] == eix_pkg::MOVE_W1_OPCODE;
    assign is_move_w2 = instr_word_in[15:eix_pkg::MOVE_W2_OP_LSB] == eix_pkg::MOVE_W2_OPCODE;

    // full 12-bit reach; the sum wraps inside the data space.
    assign src_addr = index_q + {5'h00, instr_word_in[eix_pkg::OFFS_W-1:0]};

    // indirect register detection, one comparator pair per pointer group.
    for (genvar g = 0; g < eix_pkg::IND_GRPS; g++) begin : g_ind
        assign ind_hit[g] = (src_addr >= eix_pkg::IND_GRP_BASE[g])
            && (src_addr < eix_pkg::IND_GRP_BASE[g] + eix_pkg::IND_GRP_SIZE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer next state and all output next values.

    // Pulses default low, held values keep their last content.
    always_comb begin
        state_d = state_q;
        index_d = index_q;
        src_ind_d = src_ind_q;
        pc_load_d = 1'b0;
        pc_value_d = pc_value_q;
        push_d = 1'b0;
        push_value_d = push_value_q;
        rd_req_d = 1'b0;
        rd_addr_d = rd_addr_q;
        wr_req_d = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        discard_d = 1'b0;
        if (index_load_in) begin
            index_d = index_load_value_in;
        end
        unique case (state_q)
            eix_pkg::EIX_DECODE: begin
                if (instr_valid_in && is_add_ret) begin
                    index_d = index_q + {6'h00, instr_word_in[eix_pkg::LIT_W-1:0]};
                    pc_load_d = 1'b1;
                    pc_value_d = stack_top_in;
                    state_d = eix_pkg::EIX_FLUSH;
                end else if (instr_valid_in && is_call_w) begin
                    // no working register or flag write.
                    push_d = 1'b1;
                    push_value_d = pc_in + eix_pkg::PC_STEP;
                    pc_load_d = 1'b1;
                    pc_value_d = {pc_upper_latch_in[eix_pkg::PC_W-2*eix_pkg::BYTE_W-1:0], pc_high_latch_in,
                        working_register_in};
                    state_d = eix_pkg::EIX_FLUSH;
                end else if (instr_valid_in && is_move_w1) begin
                    rd_req_d = 1'b1;
                    rd_addr_d = src_addr;
                    src_ind_d = |ind_hit;
                    state_d = eix_pkg::EIX_MOVE_W2;
                end
            end
            eix_pkg::EIX_MOVE_W2: begin
                if (instr_valid_in) begin
                    state_d = eix_pkg::EIX_DECODE;
                    if (is_move_w2) begin
                        wr_req_d = 1'b1;
                        wr_addr_d = instr_word_in[eix_pkg::ADDR_W-1:0];
                        wr_data_d = src_ind_q ? eix_pkg::INDIRECT_READ_VALUE : rd_data_in;
                    end
                end
            end
            eix_pkg::EIX_FLUSH: begin
                // idle lasts one clock.
                // The second cycle never stalls: a missing fetch must not stretch the instruction.
                discard_d = instr_valid_in;
                state_d = eix_pkg::EIX_DECODE;
            end
            default: begin
                state_d = eix_pkg::EIX_DECODE;
            end
        endcase
        // Busy follows the next state so that the port comes straight from a flip-flop.
        busy_d = state_d != eix_pkg::EIX_DECODE;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State registers.

    // Synchronous reset to idle decode with all requests low.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_q <= eix_pkg::EIX_DECODE;
            index_q <= eix_pkg::INDEX_RESET;
            src_ind_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_value_q <= eix_pkg::PC_RESET;
            push_q <= 1'b0;
            push_value_q <= eix_pkg::PC_RESET;
            rd_req_q <= 1'b0;
            rd_addr_q <= eix_pkg::INDEX_RESET;
            wr_req_q <= 1'b0;
            wr_addr_q <= eix_pkg::INDEX_RESET;
            wr_data_q <= eix_pkg::INDIRECT_READ_VALUE;
            discard_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            index_q <= index_d;
            src_ind_q <= src_ind_d;
            pc_load_q <= pc_load_d;
            pc_value_q <= pc_value_d;
            push_q <= push_d;
            push_value_q <= push_value_d;
            rd_req_q <= rd_req_d;
            rd_addr_q <= rd_addr_d;
            wr_req_q <= wr_req_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            discard_q <= discard_d;
            busy_q <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops.

    assign third_index_pointer_out = index_q;
    assign pc_load_out = pc_load_q;
    assign pc_value_out = pc_value_q;
    assign push_out = push_q;
    assign push_value_out = push_value_q;
    assign rd_req_out = rd_req_q;
    assign rd_addr_out = rd_addr_q;
    assign wr_req_out = wr_req_q;
    assign wr_addr_out = wr_addr_q;
    assign wr_data_out = wr_data_q;
    assign discard_out = discard_q;
    assign busy_out = busy_q;

endmodule

// [test/eix_exec_checker.sv]
// Assertions on the ports of the extended instruction executor.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module eix_exec_checker (
    input logic core_clk_in,
    input logic reset_in,
    input logic instr_valid_in,
    input logic [15:0] instr_word_in,
    input logic [20:0] pc_in,
    input logic [7:0] working_register_in,
    input logic [7:0] pc_high_latch_in,
    input logic [7:0] pc_upper_latch_in,
    input logic [20:0] stack_top_in,
    input logic [7:0] rd_data_in,
    input logic [11:0] third_index_pointer_out,
    input logic pc_load_out,
    input logic [20:0] pc_value_out,
    input logic push_out,
    input logic [20:0] push_value_out,
    input logic rd_req_out,
    input logic [11:0] rd_addr_out,
    input logic wr_req_out,
    input logic [11:0] wr_addr_out,
    input logic [7:0] wr_data_out,
    input logic discard_out,
    input logic busy_out
);
    logic tk, ret, cal, mv1, w2, ind, wait_q;
    // Decode of a word taken in the idle state.
    assign tk = instr_valid_in && !busy_out && !reset_in;
    assign ret = instr_word_in[15:6] == 10'h3A3;
    assign cal = instr_word_in == 16'h0014;
    assign mv1 = instr_word_in[15:7] == 9'h1D6;
    assign w2 = wait_q && instr_valid_in;
    assign ind = rd_addr_out[11:3] inside {[9'h1FB:9'h1FD]} && rd_addr_out[2:0] >= 3'h3;
    // Marks a move that still waits for its second word.
    always_ff @(posedge core_clk_in) wait_q <= !reset_in && ((tk && mv1) || (wait_q && !instr_valid_in));
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////
    property p_ret; tk && ret |=> pc_load_out && pc_value_out == $past(stack_top_in)
        && third_index_pointer_out == $past(third_index_pointer_out) + $past(instr_word_in[5:0]); endproperty
    a_ret: assert property (p_ret) else $error("return result wrong");
    property p_cal; tk && cal |=> push_out && push_value_out == $past(pc_in) + 21'h2 && pc_value_out ==
        {$past(pc_upper_latch_in[4:0]), $past(pc_high_latch_in), $past(working_register_in)}; endproperty
    a_cal: assert property (p_cal) else $error("call result wrong");
    property p_two; tk && (ret || cal) |=> busy_out ##1 !busy_out; endproperty
    a_two: assert property (p_two) else $error("two cycle flow wrong");
    property p_drop; tk && (ret || cal) ##1 instr_valid_in |=> discard_out && !pc_load_out && !rd_req_out; endproperty
    a_drop: assert property (p_drop) else $error("idle word not dropped");
    property p_src; tk && mv1 |=> rd_req_out
        && rd_addr_out == $past(third_index_pointer_out) + $past(instr_word_in[6:0]); endproperty
    a_src: assert property (p_src) else $error("source address wrong");
    property p_dst; w2 && instr_word_in[15:12] == 4'hF |=> wr_req_out && wr_addr_out == $past(instr_word_in[11:0])
        && wr_data_out == ($past(ind) ? 8'h00 : $past(rd_data_in)); endproperty
    a_dst: assert property (p_dst) else $error("move write wrong");
    property p_abort; w2 && instr_word_in[15:12] != 4'hF |=> !wr_req_out; endproperty
    a_abort: assert property (p_abort) else $error("bad second word wrote");
    property p_wr; wr_req_out |-> $past(w2); endproperty
    a_wr: assert property (p_wr) else $error("stray write");
    c_ret: cover property (tk && ret);
    c_cal: cover property (tk && cal);
    c_ind: cover property (wr_req_out && $past(ind));
endmodule
bind eix_exec eix_exec_checker u_chk (.*);

// [test/eix_mem_model.sv]
// Far-side data memory: answers the executor's reads and takes its writes.
// Assumes the read address holds while a move waits for its second word.
`timescale 1ns/100ps
module eix_mem_model (
    input logic clk_in,
    input logic busy_in,
    input logic rd_req_in,
    input logic [11:0] rd_addr_in,
    input logic wr_req_in,
    input logic [11:0] wr_addr_in,
    input logic [7:0] wr_data_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem_q [4096];
    logic pend_q = 1'b0;
    // Each location starts with a pattern made from its address.
    initial foreach (mem_q[i]) mem_q[i] = 8'(i) ^ 8'hA5;
    // full data space
    // Outside a pending read the bus shows the inverse, never stale data.
    assign rd_data_out = (rd_req_in || pend_q) ? mem_q[rd_addr_in] : ~mem_q[rd_addr_in];
    // Keeps a read open while the move waits for its second word, and stores the write.
    always @(posedge clk_in) begin
        pend_q <= rd_req_in || (pend_q && busy_in);
        if (wr_req_in)
            mem_q[wr_addr_in] <= wr_data_in;
    end
endmodule

// [test/eix_exec_tb.sv]
// Random and corner-case bench for the extended instruction executor.
// Assumes the data memory model on the far side and the bound checker.
`timescale 1ns/100ps
module eix_exec_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic vld = 1'b0;
    logic ild = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic [20:0] pc = 21'h000000;
    logic [20:0] stk = 21'h000000;
    logic [23:0] lat = 24'h000000;
    logic [11:0] ilv = 12'h000;
    logic [20:0] pcv, psv;
    logic [11:0] ptr, rda, wra, d, a;
    logic [7:0] rdd, wrd;
    logic [6:0] z;
    logic [1:0] op;
    logic pc_low_byte, psh, rdq, wrq, dsc, bsy;
    logic [31:0] r = 32'h6DD67824;
    int mismatches = 0;
    int n_tests = 0;
    // Core clock at 200 MHz.
    always #2.5 clk = ~clk;
    eix_exec u_dut (.core_clk_in(clk), .reset_in(rst), .instr_valid_in(vld), .instr_word_in(wd), .pc_in(pc),
        .working_register_in(lat[7:0]), .pc_high_latch_in(lat[15:8]), .pc_upper_latch_in(lat[23:16]),
        .stack_top_in(stk), .index_load_in(ild), .index_load_value_in(ilv), .rd_data_in(rdd),
        .third_index_pointer_out(ptr), .pc_load_out(pc_low_byte), .pc_value_out(pcv), .push_out(psh),
        .push_value_out(psv), .rd_req_out(rdq), .rd_addr_out(rda), .wr_req_out(wrq), .wr_addr_out(wra),
        .wr_data_out(wrd), .discard_out(dsc), .busy_out(bsy));
    eix_mem_model u_mem (.clk_in(clk), .busy_in(bsy), .rd_req_in(rdq), .rd_addr_in(rda), .wr_req_in(wrq),
        .wr_addr_in(wra),
        .wr_data_in(wrd), .rd_data_out(rdd));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected moved byte: zero for indirect registers, else the memory content.
    function automatic logic [7:0] src_val(logic [11:0] x);
        return (x[11:3] inside {[9'h1FB:9'h1FD]} && x[2:0] >= 3'h3) ? 8'h00 : u_mem.mem_q[x];
    endfunction
    task automatic chk(string nm, logic [23:0] xv, logic [23:0] gv);
        n_tests++;
        if (gv !== xv) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, xv, gv);
        end
    endtask
    // Presents one word for one cycle; the caller checks at the next falling edge.
    task automatic give(logic [15:0] w);
        wd = w;
        vld = 1'b1;
        @(negedge clk);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog against a hang.
    initial begin
        #20000;
        mismatches++;
        test_done();
    end
    // Main sequence: pointer load, then one instruction flow per pass.
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 60; i++) begin
            r = nxt(r);
            vld = 1'b0;
            ilv = (i % 5 == 0) ? 12'hFE0 : r[27:16];
            ild = 1'b1;
            @(negedge clk);
            ild = 1'b0;
            chk("pointer", ilv, ptr);
            pc = {r[19:0], 1'b0};
            lat = r[31:8];
            stk = r[20:0];
            op = (i % 5 == 0) ? 2'd2 : (i < 4) ? 2'(i - 1) : r[30:29];
            z = (i % 10 == 0) ? 7'h7F : (i % 5 == 0) ? 7'h05 : r[6:0];
            a = ilv + z;
            d = r[23:12];
            if (d inside {12'hFF9, [12'hFFD:12'hFFF]}) d[4] = 1'b0;
            if (op == 2'd0) begin
                give({10'h3A3, (i == 1) ? 6'h3F : r[5:0]});
                chk("return", {2'b11, stk}, {pc_low_byte, bsy, pcv});
                chk("return pointer", 12'(ilv + wd[5:0]), ptr);
            end else if (op == 2'd1) begin
                give(16'h0014);
                chk("call push", {1'b1, 21'(pc + 21'h2)}, {psh, psv});
                chk("call target", {2'b11, lat[20:0]}, {pc_low_byte, bsy, pcv});
            end else begin
                give({9'h1D6, z});
                chk("source", {1'b1, a}, {rdq, rda});
                give((op == 2'd2) ? {4'hF, d} : {4'h7, d});
                chk("write strobe", op == 2'd2, wrq);
                if (op == 2'd2) chk("write", {d, src_val(a)}, {wra, wrd});
            end
            if (op < 2'd2 && i % 3 == 0) begin
                vld = 1'b0;
                @(negedge clk);
                chk("idle", 3'b000, {pc_low_byte, bsy, dsc});
            end else if (op < 2'd2) begin
                give(r[15:0]);
                chk("drop", 3'b001, {pc_low_byte, bsy, dsc});
            end
            $display("pass %0d op %0d done", i, op);
        end
        test_done();
    end
endmodule
